// [core/aec_adc_end.sv]
// converter end: mode decode, wake timing, conversion and echoed readout
// assumes link pins come from another domain and sample_code is local
`timescale 1ns/1ns
`default_nettype none
`include "aec_consts.svh"

module aec_adc_end
  import aec_pkg::*;
#(
  parameter int WAKE_PD_CYC  = `AEC_CYC_US(`AEC_WAKE_PD_US),
  parameter int WAKE_INT_CYC = `AEC_CYC_US(`AEC_WAKE_INT_US),
  parameter int W            = `AEC_WORD_BITS
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  aec_link_if.dev           link,
  input  wire logic [W-1:0] sample_code,
  output logic              bw_narrow,
  output logic              cm_enable,
  output logic              power_down,
  output logic              snooze,
  output logic              test_mode,
  output logic              invalid_mode,
  output logic              wake_ready,
  output logic              converting
);

  // ------------------------------------------------------------
  // timing counts
  // ------------------------------------------------------------
  localparam int WAKE_SNZ_CYC = `AEC_CYC_US(`AEC_WAKE_SNZ_US);
  localparam int TMSB_CYC     = `AEC_CYC_NS(`AEC_TMSB_NS);
  localparam int WW           = `AEC_WAKE_W;
  localparam int TW           = `AEC_TIM_W;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [6:0] pin_raw;
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  logic       cnv_s3_q;
  logic       sclk_s3_q;

  // {low_reference_input, cm, bw, hi, lo, sclk, cnv}
  assign pin_raw = {link.low_reference_input, link.cm_output_enable,
                    link.bandwidth_sel, link.ref_mode_sel_hi,
                    link.ref_mode_sel_lo, link.serial_clk,
                    link.conversion_start};

  // two stages, then one more for edge detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_q  <= 7'h00;
      pin_s2_q  <= 7'h00;
      cnv_s3_q  <= 1'b0;
      sclk_s3_q <= 1'b0;
    end else begin
      pin_s1_q  <= pin_raw;
      pin_s2_q  <= pin_s1_q;
      cnv_s3_q  <= pin_s2_q[0];
      sclk_s3_q <= pin_s2_q[1];
    end
  end

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  aec_mode_t mode_now;
  aec_mode_t mode_prev_q;
  logic      int_buf;
  logic      link_on;
  logic      awake;
  logic [WW-1:0] wake_q;

  assign mode_now = aec_mode_f(pin_s2_q[5:2]);
  // internal buffer: lo set, hi clear, low reference present
  assign int_buf  = pin_s2_q[2] & ~pin_s2_q[3] & pin_s2_q[6];
  assign link_on  = aec_awake_f(mode_now);
  // not ready in the cycle a wake begins
  assign awake    = link_on && (wake_q == '0) && aec_awake_f(mode_prev_q);

  // wake counter, loaded when leaving a low-power mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_prev_q <= AEC_MD_PD;
      wake_q      <= '0;
    end else begin
      mode_prev_q <= mode_now;
      if (!link_on) begin
        wake_q <= '0;
      end else if (mode_prev_q == AEC_MD_PD) begin
        wake_q <= int_buf ? WW'(WAKE_INT_CYC) : WW'(WAKE_PD_CYC);
      end else if (mode_prev_q == AEC_MD_SNOOZE) begin
        wake_q <= int_buf ? WW'(WAKE_INT_CYC) : WW'(WAKE_SNZ_CYC);
      end else if (wake_q != '0) begin
        wake_q <= wake_q - 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------
  // registered pin and mode status
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bw_narrow    <= 1'b0;
      cm_enable    <= 1'b0;
      power_down   <= 1'b1;
      snooze       <= 1'b0;
      test_mode    <= 1'b0;
      invalid_mode <= 1'b0;
      wake_ready   <= 1'b0;
    end else begin
      bw_narrow    <= pin_s2_q[4];
      cm_enable    <= pin_s2_q[5];
      power_down   <= (mode_now == AEC_MD_PD);
      snooze       <= (mode_now == AEC_MD_SNOOZE);
      test_mode    <= (mode_now == AEC_MD_TEST);
      invalid_mode <= (mode_now == AEC_MD_INVALID);
      wake_ready   <= awake;
    end
  end

  // ------------------------------------------------------------
  // conversion
  // ------------------------------------------------------------
  logic          cnv_rise;
  logic          start_ok;
  logic [TW-1:0] conv_q;
  logic [W-1:0]  word_q;
  logic          pat_flip_q;

  assign cnv_rise = pin_s2_q[0] & ~cnv_s3_q;
  assign start_ok = cnv_rise && awake && (conv_q == '0);

  // conversion phase timer and result capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_q     <= '0;
      word_q     <= '0;
      pat_flip_q <= 1'b0;
      converting <= 1'b0;
    end else begin
      converting <= (conv_q > TW'(1)) || start_ok;
      if (start_ok) begin
        conv_q <= TW'(TMSB_CYC);
        if (mode_now == AEC_MD_TEST) begin
          word_q     <= pat_flip_q ? ~`AEC_TEST_PAT : `AEC_TEST_PAT;
          pat_flip_q <= ~pat_flip_q;
        end else begin
          word_q <= sample_code;
        end
      end else if (conv_q != '0) begin
        conv_q <= conv_q - 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // echoed clock readout
  // ------------------------------------------------------------
  logic         sclk_fall;
  logic         frame_q;
  logic [W-1:0] shift_q;
  logic [4:0]   bits_q;

  assign sclk_fall = ~pin_s2_q[1] & sclk_s3_q;

  // frame opens at msb-ready, closes after the last bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_q               <= 1'b0;
      shift_q               <= '0;
      bits_q                <= 5'h00;
      link.serial_data      <= 1'b0;
      link.echoed_clock_out <= 1'b0;
    end else if (!link_on) begin
      frame_q               <= 1'b0;
      link.serial_data      <= 1'b0;
      link.echoed_clock_out <= 1'b0;
    end else if (conv_q == TW'(1)) begin
      frame_q               <= 1'b1;
      shift_q               <= word_q;
      bits_q                <= 5'h00;
      link.serial_data      <= word_q[W-1];
      link.echoed_clock_out <= 1'b0;
    end else begin
      // echo is the gated serial clock
      link.echoed_clock_out <= frame_q & pin_s2_q[1];
      if (sclk_fall && frame_q) begin
        bits_q  <= bits_q + 1'b1;
        shift_q <= shift_q << 1;
        if (bits_q == 5'(W - 1)) begin
          // both lines low after last bit
          frame_q          <= 1'b0;
          link.serial_data <= 1'b0;
        end else begin
          link.serial_data <= shift_q[W-2];
        end
      end
    end
  end

endmodule
`default_nettype wire

// [core/aec_host_end.sv]
// host end: drives mode pins and start, bursts the serial clock,
// shifts the echoed data in; software reaches it over a plain port
// assumes the echoed clock and data arrive from another domain
`timescale 1ns/1ns
`default_nettype none
`include "aec_consts.svh"

module aec_host_end
  import aec_pkg::*;
#(
  parameter int WAKE_PD_CYC  = `AEC_CYC_US(`AEC_WAKE_PD_US),
  parameter int WAKE_INT_CYC = `AEC_CYC_US(`AEC_WAKE_INT_US),
  parameter int W            = `AEC_WORD_BITS
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  aec_link_if.host          link,
  input  wire logic [1:0]   reg_addr,
  input  wire logic [W-1:0] reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [W-1:0]      reg_rdata
);

  // ------------------------------------------------------------
  // timing counts
  // ------------------------------------------------------------
  localparam int WAKE_SNZ_CYC = `AEC_CYC_US(`AEC_WAKE_SNZ_US);
  localparam int TMSB_CYC     = `AEC_CYC_NS(`AEC_TMSB_NS);
  localparam int CNVH_CYC     = `AEC_CYC_NS(`AEC_CNVH_NS);
  localparam int HALF_CYC     = `AEC_CYC_NS(`AEC_SCLK_HALF_NS);
  localparam int NPER_CYC     = `AEC_CYC_NS(`AEC_NARROW_PER_NS);
  localparam int WW           = `AEC_WAKE_W;
  localparam int TW           = `AEC_TIM_W;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_MSB   = 2'b10,
    ST_BURST = 2'b11
  } aec_hst_t;

  // ------------------------------------------------------------
  // mode pins and wake timer
  // ------------------------------------------------------------
  logic [3:0]    pins_now;
  aec_mode_t     mode_old;
  aec_mode_t     mode_new;
  logic [WW-1:0] wake_q;
  logic          awake;
  logic          wr_ctrl;
  logic          int_new;

  assign pins_now = {link.cm_output_enable, link.bandwidth_sel,
                     link.ref_mode_sel_hi, link.ref_mode_sel_lo};
  assign mode_old = aec_mode_f(pins_now);
  assign mode_new = aec_mode_f(reg_wdata[3:0]);
  assign wr_ctrl  = reg_wr && (reg_addr == `AEC_REG_CTRL);
  assign int_new  = reg_wdata[0] & ~reg_wdata[1] & reg_wdata[`AEC_CTRL_LOREF];
  assign awake    = aec_awake_f(mode_old) && (wake_q == '0);

  // pins start in power-down and change only by software
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {link.low_reference_input, link.cm_output_enable, link.bandwidth_sel,
       link.ref_mode_sel_hi, link.ref_mode_sel_lo} <= `AEC_CTRL_RESET;
    end else if (wr_ctrl) begin
      {link.low_reference_input, link.cm_output_enable, link.bandwidth_sel,
       link.ref_mode_sel_hi, link.ref_mode_sel_lo} <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_q <= '0;
    end else if (wr_ctrl && !aec_awake_f(mode_new)) begin
      wake_q <= '0;
    end else if (wr_ctrl && mode_old == AEC_MD_PD) begin
      wake_q <= int_new ? WW'(WAKE_INT_CYC) : WW'(WAKE_PD_CYC);
    end else if (wr_ctrl && mode_old == AEC_MD_SNOOZE) begin
      wake_q <= int_new ? WW'(WAKE_INT_CYC) : WW'(WAKE_SNZ_CYC);
    end else if (wake_q != '0) begin
      wake_q <= wake_q - 1'b1;
    end
  end

  // ------------------------------------------------------------
  // frame sequencer
  // ------------------------------------------------------------
  aec_hst_t      st_q;
  logic [TW-1:0] tim_q;
  logic [TW-1:0] per_q;
  logic [5:0]    edges_q;
  logic          go;

  // narrow bandwidth spacing enforced by per_q
  assign go = reg_wr && (reg_addr == `AEC_REG_CMD) &&
              reg_wdata[`AEC_CMD_START] && (st_q == ST_IDLE) &&
              awake && (per_q == '0);

  // start pulse, msb wait and clock burst
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q                  <= ST_IDLE;
      tim_q                 <= '0;
      per_q                 <= '0;
      edges_q               <= 6'h00;
      link.conversion_start <= 1'b0;
      link.serial_clk       <= 1'b0;
    end else begin
      if (per_q != '0) per_q <= per_q - 1'b1;
      if (tim_q != '0) tim_q <= tim_q - 1'b1;
      case (st_q)
        ST_IDLE: begin
          if (go) begin
            st_q                  <= ST_START;
            tim_q                 <= TW'(CNVH_CYC - 1);
            per_q                 <= link.bandwidth_sel ? TW'(NPER_CYC - 1) : '0;
            link.conversion_start <= 1'b1;
          end
        end
        ST_START: begin
          // start high for a bounded time
          if (tim_q == '0) begin
            st_q                  <= ST_MSB;
            tim_q                 <= TW'(TMSB_CYC - 1);
            link.conversion_start <= 1'b0;
          end
        end
        ST_MSB: begin
          if (tim_q == '0) begin
            st_q    <= ST_BURST;
            tim_q   <= TW'(HALF_CYC - 1);
            edges_q <= 6'h00;
          end
        end
        ST_BURST: begin
          if (edges_q == `AEC_BURST_EDGES) begin
            st_q            <= ST_IDLE;
            link.serial_clk <= 1'b0;
          end else if (tim_q == '0) begin
            link.serial_clk <= ~link.serial_clk;
            edges_q         <= edges_q + 1'b1;
            tim_q           <= TW'(HALF_CYC - 1);
          end
        end
        default: begin
          // unknown state: back to idle, clock low
          st_q            <= ST_IDLE;
          link.serial_clk <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // capture of echoed data
  // ------------------------------------------------------------
  logic [1:0]   echo_s1_q;
  logic [1:0]   echo_s2_q;
  logic         echo_s3_q;
  logic [W-1:0] shin_q;
  logic [4:0]   cap_q;
  logic [W-1:0] result_q;
  logic         new_q;
  logic         rd_data;

  assign rd_data = reg_rd && (reg_addr == `AEC_REG_DATA);

  // {data, echo} synchronisers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      echo_s1_q <= 2'h0;
      echo_s2_q <= 2'h0;
      echo_s3_q <= 1'b0;
    end else begin
      echo_s1_q <= {link.serial_data, link.echoed_clock_out};
      echo_s2_q <= echo_s1_q;
      echo_s3_q <= echo_s2_q[0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shin_q   <= '0;
      cap_q    <= 5'h00;
      result_q <= '0;
      new_q    <= 1'b0;
    end else begin
      if (st_q == ST_START) begin
        cap_q <= 5'h00;
      end else if (echo_s2_q[0] && !echo_s3_q && cap_q != 5'(W)) begin
        shin_q <= {shin_q[W-2:0], echo_s2_q[1]};
        cap_q  <= cap_q + 1'b1;
      end
      // set wins over the clear by read
      if (cap_q == 5'(W - 1) && echo_s2_q[0] && !echo_s3_q) begin
        result_q <= {shin_q[W-2:0], echo_s2_q[1]};
        new_q    <= 1'b1;
      end else if (rd_data) begin
        new_q <= 1'b0;
      end
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `AEC_REG_CTRL:   reg_rdata <= W'({link.low_reference_input, pins_now});
        `AEC_REG_STATUS: reg_rdata <= W'({new_q, awake, st_q != ST_IDLE});
        `AEC_REG_DATA:   reg_rdata <= result_q;
        default:         reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule
`default_nettype wire

// [include/aec_consts.svh]
// constants for the echoed-clock converter link: timing, fields, offsets
// assumes a 20 MHz system clock on both ends
`ifndef AEC_CONSTS_SVH
`define AEC_CONSTS_SVH

// ------------------------------------------------------------
// clock and timing figures
// ------------------------------------------------------------
`define AEC_CLK_MHZ        20
`define AEC_WAKE_PD_US     1400
`define AEC_WAKE_INT_US    8000
`define AEC_WAKE_SNZ_US    5
`define AEC_TMSB_NS        200
`define AEC_CNVH_NS        100
`define AEC_SCLK_HALF_NS   200
`define AEC_NARROW_PER_NS  500
// least times round up to whole cycles
`define AEC_CYC_NS(ns)     ((((ns) * `AEC_CLK_MHZ) + 999) / 1000)
`define AEC_CYC_US(us)     ((us) * `AEC_CLK_MHZ)

// ------------------------------------------------------------
// widths and fixed values
// ------------------------------------------------------------
`define AEC_WORD_BITS      16
`define AEC_WAKE_W         18
`define AEC_TIM_W          8
`define AEC_TEST_PAT       16'hA5A5
`define AEC_BURST_EDGES    6'h20

// ------------------------------------------------------------
// host register offsets and fields
// ------------------------------------------------------------
`define AEC_REG_CTRL       2'h0
`define AEC_REG_CMD        2'h1
`define AEC_REG_STATUS     2'h2
`define AEC_REG_DATA       2'h3
`define AEC_CTRL_LOREF     4
`define AEC_CMD_START      0
`define AEC_ST_BUSY        0
`define AEC_ST_AWAKE       1
`define AEC_ST_NEW         2
`define AEC_CTRL_RESET     5'h00

`endif

// [include/aec_link_if.sv]
// link between converter end and host end: start, clocks, data, mode pins
// assumes the bench joins both ends through this interface
`timescale 1ns/1ns
`default_nettype none
interface aec_link_if;
  logic conversion_start;
  logic serial_clk;
  logic echoed_clock_out;
  logic serial_data;
  logic ref_mode_sel_lo;
  logic ref_mode_sel_hi;
  logic bandwidth_sel;
  logic cm_output_enable;
  logic low_reference_input;

  modport dev (
    input  conversion_start, serial_clk, ref_mode_sel_lo, ref_mode_sel_hi,
    input  bandwidth_sel, cm_output_enable, low_reference_input,
    output echoed_clock_out, serial_data
  );

  modport host (
    output conversion_start, serial_clk, ref_mode_sel_lo, ref_mode_sel_hi,
    output bandwidth_sel, cm_output_enable, low_reference_input,
    input  echoed_clock_out, serial_data
  );
endinterface
`default_nettype wire

// [include/aec_pkg.sv]
// types shared by both ends of the converter link
// assumes nothing beyond the constants header
`default_nettype none
package aec_pkg;

  // ------------------------------------------------------------
  // operating modes decoded from the four mode pins
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    AEC_MD_PD      = 3'b000,
    AEC_MD_ACT     = 3'b001,
    AEC_MD_SNOOZE  = 3'b010,
    AEC_MD_TEST    = 3'b011,
    AEC_MD_INVALID = 3'b100
  } aec_mode_t;

  // pins ordered {cm, bw, hi, lo}
  function automatic aec_mode_t aec_mode_f(input logic [3:0] pins);
    aec_mode_t m;
    m = AEC_MD_ACT;
    if (pins[2:0] == 3'b000) m = AEC_MD_PD;
    else if (pins[1:0] == 2'b11) m = AEC_MD_SNOOZE;
    else if (pins[2:0] == 3'b100) m = pins[3] ? AEC_MD_INVALID : AEC_MD_TEST;
    return m;
  endfunction

  // awake means the link and converter may run
  function automatic logic aec_awake_f(input aec_mode_t m);
    return (m == AEC_MD_ACT) || (m == AEC_MD_TEST);
  endfunction

endpackage
`default_nettype wire

// [tb/adc_mode_and_echoed_clock_readout_test.sv]
// bench: software port of the host end drives the link to the converter end
// assumes small wake counts on both ends and a 20 MHz clock
`timescale 1ns/1ns
`default_nettype none
module adc_mode_and_echoed_clock_readout_test;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam int PD_CYC  = 40;
  localparam int INT_CYC = 60;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [1:0]  reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] sample_code = 16'h0000;
  logic [15:0] rv;
  logic        bw_narrow, cm_enable, power_down, snooze, test_mode, invalid_mode;
  logic        wake_ready, converting;
  int          err_total = 0;
  int          total_checks = 0;
  logic [4:0]  modes [9] = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h08, 5'h03, 5'h07, 5'h04, 5'h0C};
  logic [15:0] codes [4] = '{16'h7FFF, 16'h8000, 16'h0001, 16'hFFFF};
  // clock
  always #25 clk = ~clk;
  aec_link_if link ();
  aec_adc_end #(.WAKE_PD_CYC(PD_CYC), .WAKE_INT_CYC(INT_CYC)) u_aec_adc_end (
    .clk(clk), .reset_n(reset_n), .link(link), .sample_code(sample_code),
    .bw_narrow(bw_narrow), .cm_enable(cm_enable), .power_down(power_down),
    .snooze(snooze), .test_mode(test_mode), .invalid_mode(invalid_mode),
    .wake_ready(wake_ready), .converting(converting));
  aec_host_end #(.WAKE_PD_CYC(PD_CYC), .WAKE_INT_CYC(INT_CYC)) u_aec_host_end (
    .clk(clk), .reset_n(reset_n), .link(link), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  aec_link_props u_aec_link_props (
    .clk(clk), .reset_n(reset_n), .conversion_start(link.conversion_start),
    .serial_clk(link.serial_clk), .echoed_clock_out(link.echoed_clock_out),
    .serial_data(link.serial_data), .ref_mode_sel_lo(link.ref_mode_sel_lo),
    .ref_mode_sel_hi(link.ref_mode_sel_hi), .bandwidth_sel(link.bandwidth_sel),
    .cm_output_enable(link.cm_output_enable),
    .low_reference_input(link.low_reference_input));
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // set mode pins, then compare the decoded outputs
  task automatic mode(input logic [4:0] c);
    wr(2'h0, {11'h000, c});
    repeat (6) @(posedge clk);
    #1 chk({10'h000, bw_narrow, cm_enable,
      power_down, snooze, test_mode, invalid_mode},
      {10'h000, c[2], c[3], c[2:0] == 3'h0, c[1:0] == 2'h3,
       c[2:0] == 3'h4 && !c[3], c[2:0] == 3'h4 && c[3]});
  endtask
  // leave a sleep mode, ready must not come early nor late
  task automatic wake(input logic [4:0] c, input int lo, input int hi);
    wr(2'h0, {11'h000, c});
    repeat (3) @(posedge clk);
    #1 chk({15'h0000, wake_ready}, 16'h0000);
    repeat (lo - 3) @(posedge clk);
    #1 chk({15'h0000, wake_ready}, 16'h0000);
    repeat (hi - lo) @(posedge clk);
    #1 chk({15'h0000, wake_ready}, 16'h0001);
  endtask
  // poll status until a new word is in, bounded
  task automatic wait_new();
    int n = 0;
    rv = 16'h0000;
    while (rv[2] !== 1'b1 && n < 200) begin
      rd(2'h2, rv);
      n++;
    end
    chk(rv & 16'h0004, 16'h0004);
  endtask
  task automatic conv(input logic [15:0] code, input logic [15:0] exp);
    @(posedge clk);
    sample_code <= code;
    wr(2'h1, 16'h0001);
    wait_new();
    rd(2'h3, rv);
    chk(rv, exp);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 chk({15'h0000, power_down}, 16'h0001);
    rd(2'h2, rv);
    chk(rv, 16'h0000);
    foreach (modes[i]) mode(modes[i]);
    mode(5'h00);
    wake(5'h01, PD_CYC - 10, PD_CYC + 10);
    foreach (codes[i]) conv(codes[i], codes[i]);
    mode(5'h03);
    wr(2'h1, 16'h0001);
    repeat (40) @(posedge clk);
    rd(2'h2, rv);
    chk(rv, 16'h0000);
    wake(5'h01, 90, 115);
    mode(5'h00);
    wake(5'h11, INT_CYC - 10, INT_CYC + 10);
    mode(5'h13);
    wake(5'h11, INT_CYC - 10, INT_CYC + 10);
    conv(16'h4321, 16'h4321);
    mode(5'h04);
    conv(16'h1111, 16'hA5A5);
    conv(16'h1111, 16'h5A5A);
    mode(5'h05);
    @(posedge clk);
    sample_code <= 16'h1357;
    wr(2'h1, 16'h0001);
    repeat (3) @(posedge clk);
    #1 chk({15'h0000, converting}, 16'h0001);
    repeat (5) @(posedge clk);
    sample_code <= 16'h2468;
    wr(2'h1, 16'h0001);
    wait_new();
    rd(2'h3, rv);
    chk(rv, 16'h1357);
    tally_and_finish();
  end
  // watchdog: the sequence needs some 1700 cycles
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [tb/aec_link_props.sv]
// checker for the converter link wires between host end and converter end
// assumes one clock domain and an instance beside the link interface
`timescale 1ns/1ns
`default_nettype none
module aec_link_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic conversion_start,
  input wire logic serial_clk,
  input wire logic echoed_clock_out,
  input wire logic serial_data,
  input wire logic ref_mode_sel_lo,
  input wire logic ref_mode_sel_hi,
  input wire logic bandwidth_sel,
  input wire logic cm_output_enable,
  input wire logic low_reference_input
);
  // ----------------------------------------
  // frame bit counter
  // ----------------------------------------
  logic       start_q;
  logic       echo_q;
  logic [4:0] bits_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // echo rises since the last start pin rise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      start_q <= 1'b0;
      echo_q  <= 1'b0;
      bits_q  <= 5'h00;
    end else begin
      start_q <= conversion_start;
      echo_q  <= echoed_clock_out;
      if (conversion_start && !start_q) bits_q <= 5'h00;
      else if (echoed_clock_out && !echo_q) bits_q <= bits_q + 5'h01;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_start_width: assert property ($rose(conversion_start) |=>
    conversion_start ##1 !conversion_start) else $error("start pulse width wrong");
  a_start_awake: assert property ($rose(conversion_start) |->
    (ref_mode_sel_hi ^ ref_mode_sel_lo) ||
    (bandwidth_sel && !cm_output_enable && !ref_mode_sel_hi && !ref_mode_sel_lo))
    else $error("start while not in an active mode");
  a_msb_gate: assert property ($rose(conversion_start) |-> !serial_clk [*8])
    else $error("serial clock before msb ready");
  a_sclk_high: assert property ($rose(serial_clk) |-> serial_clk [*4] ##1 !serial_clk)
    else $error("serial clock high time wrong");
  a_sclk_low: assert property ($fell(serial_clk) |-> !serial_clk [*4])
    else $error("serial clock low time short");
  a_echo_lag: assert property ($rose(serial_clk) && bits_q < 5'h10 |->
    ##[1:4] echoed_clock_out) else $error("echo missing after serial clock rise");
  a_echo_fall: assert property ($fell(echoed_clock_out) |-> !serial_clk)
    else $error("echo fell while serial clock high");
  a_data_on_fall: assert property ($changed(serial_data) |-> !echoed_clock_out)
    else $error("data changed while echo high");
  a_frame_count: assert property (bits_q <= 5'h10)
    else $error("more than sixteen echo pulses in a frame");
  a_tail_zero: assert property (bits_q == 5'h10 && !echoed_clock_out |-> !serial_data)
    else $error("data not low after last bit");
  a_narrow_gap: assert property ($rose(conversion_start) && bandwidth_sel |=>
    (!$rose(conversion_start)) [*8]) else $error("narrow start spacing too short");
  // main scenarios
  c_start: cover property ($rose(conversion_start));
  c_full_frame: cover property (bits_q == 5'h10);
  c_narrow: cover property ($rose(conversion_start) && bandwidth_sel);
  c_int_ref: cover property ($rose(conversion_start) && low_reference_input);
endmodule
`default_nettype wire
